// File: logic/apc_config_regs.v
// apc_config_regs.v: two 16-bit audio path configuration registers
// loaded over the serial port; assumes host drives ss_n, sclk, mosi
// asynchronously (mode 0, msb first) and pu from the power control
`timescale 1ns/1ns
`include "apc_regs.vh"
`default_nettype none
module apc_config_regs (
  input  wire        clk,
  input  wire        rst,
  input  wire        ss_n,
  input  wire        sclk,
  input  wire        mosi,
  input  wire        master_power_bit,
  output reg  [15:0] audio_path_config_a_reg,
  output reg  [15:0] audio_path_config_b_reg,
  output reg         agc_amp_powerdown,
  output reg         lowpass_powerdown,
  output reg  [1:0]  rate_filter_select,
  output reg         filter_source_select,
  output reg  [1:0]  second_mixer_mode,
  output reg  [1:0]  first_mixer_mode,
  output reg  [1:0]  first_mixer_source_select,
  output reg  [2:0]  attenuation_level,
  output reg  [4:0]  attenuation_db,
  output reg  [1:0]  volume_source_select,
  output reg  [2:0]  analog_out_source_select,
  output reg         analog_out_powerdown,
  output reg  [1:0]  output_source_select,
  output reg  [1:0]  speaker_aux_control,
  output reg         volume_powerdown,
  output reg         input_source_select,
  output reg         aux_in_powerdown,
  output reg  [1:0]  aux_in_gain,
  output reg         analog_in_powerdown,
  output reg  [1:0]  analog_in_gain,
  output reg         second_mixer_powerdown,
  output reg         first_mixer_powerdown
);
  wire                    ss_n_s;
  wire                    sclk_s;
  wire                    mosi_s;
  wire                    pu_s;
  wire [`APC_FRAME_W-1:0] frame;
  wire [`APC_CNT_W-1:0]   bit_cnt;
  wire                    ss_rise;
  wire [`APC_OPC_W-1:0]   opc;
  wire [`APC_DATA_W-1:0]  data;
  wire                    full_frame;
  wire                    is_load_a;
  wire                    is_load_b;
  reg  [15:0]             hold_a_reg;
  reg  [15:0]             eff_a;
  reg  [15:0]             eff_b;

  // pins from outside are filtered through four flops each
  apc_sync #(.RST_VAL(1'b1)) u_sync_ss (
    .clk  (clk),
    .rst  (rst),
    .din  (ss_n),
    .dout (ss_n_s)
  );
  apc_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .clk  (clk),
    .rst  (rst),
    .din  (sclk),
    .dout (sclk_s)
  );
  apc_sync #(.RST_VAL(1'b0)) u_sync_mosi (
    .clk  (clk),
    .rst  (rst),
    .din  (mosi),
    .dout (mosi_s)
  );
  apc_sync #(.RST_VAL(1'b0)) u_sync_pu (
    .clk  (clk),
    .rst  (rst),
    .din  (master_power_bit),
    .dout (pu_s)
  );

  apc_serial_rx u_rx (
    .clk     (clk),
    .rst     (rst),
    .ss_n    (ss_n_s),
    .sclk    (sclk_s),
    .mosi    (mosi_s),
    .frame   (frame),
    .bit_cnt (bit_cnt),
    .ss_rise (ss_rise)
  );

  // a frame counts only with exactly 24 bits; short or long frames drop
  assign opc        = frame[`APC_FRAME_W-1:`APC_DATA_W];
  assign data       = frame[`APC_DATA_W-1:0];
  assign full_frame = (bit_cnt == `APC_FRAME_W);
  assign is_load_a = ss_rise & full_frame &
                     ((opc & `APC_OPC_MASK) == `APC_OPC_LOAD_A);
  assign is_load_b = ss_rise & full_frame &
                     ((opc & `APC_OPC_MASK) == `APC_OPC_LOAD_B);

  // register loads; ss_rise is the select rising edge, so commit lands
  // there; loads are taken regardless of master power
  always @(posedge clk)
  begin
    if (rst)
    begin
      hold_a_reg              <= `APC_RST_A;
      audio_path_config_a_reg <= `APC_RST_A;
      audio_path_config_b_reg <= `APC_RST_B;
    end
    else
    begin
      if (is_load_a)
        hold_a_reg <= data;
      if (is_load_b)
      begin
        audio_path_config_b_reg <= data;
        audio_path_config_a_reg <= hold_a_reg;
      end
    end
  end

  // gate by master power: while off every stage reads powered down
  // muxes read their reset codes as well, not the committed ones
  always @*
  begin
    eff_a = audio_path_config_a_reg;
    eff_b = audio_path_config_b_reg;
    if (!pu_s)
    begin
      eff_a = `APC_RST_A;
      eff_b = `APC_RST_B;
    end
  end

  // decoded field outputs, each registered
  always @(posedge clk)
  begin
    if (rst)
    begin
      agc_amp_powerdown         <= 1'b1;
      lowpass_powerdown         <= 1'b1;
      rate_filter_select        <= 2'h3;
      filter_source_select      <= 1'b1;
      second_mixer_mode         <= 2'h3;
      first_mixer_mode          <= 2'h3;
      first_mixer_source_select <= 2'h3;
      attenuation_level         <= 3'h7;
      attenuation_db            <= 5'h1c;
      volume_source_select      <= 2'h3;
      analog_out_source_select  <= 3'h0;
      analog_out_powerdown      <= 1'b1;
      output_source_select      <= 2'h0;
      speaker_aux_control       <= 2'h0;
      volume_powerdown          <= 1'b1;
      input_source_select       <= 1'b0;
      aux_in_powerdown          <= 1'b1;
      aux_in_gain               <= 2'h0;
      analog_in_powerdown       <= 1'b1;
      analog_in_gain            <= 2'h0;
      second_mixer_powerdown    <= 1'b1;
      first_mixer_powerdown     <= 1'b1;
    end
    else
    begin
      agc_amp_powerdown    <= eff_b[`APC_B_AGC_PD];
      lowpass_powerdown    <= eff_b[`APC_B_LPF_PD];
      rate_filter_select   <= eff_b[`APC_B_RATE_HI:`APC_B_RATE_LO];
      filter_source_select <= eff_b[`APC_B_FILT_SRC];
      second_mixer_mode    <= eff_b[`APC_B_MIX2_HI:`APC_B_MIX2_LO];
      second_mixer_powerdown <=
        (eff_b[`APC_B_MIX2_HI:`APC_B_MIX2_LO] == `APC_MIX_OFF);
      first_mixer_mode     <= eff_b[`APC_B_MIX1_HI:`APC_B_MIX1_LO];
      first_mixer_powerdown <=
        (eff_b[`APC_B_MIX1_HI:`APC_B_MIX1_LO] == `APC_MIX_OFF);
      first_mixer_source_select <= eff_b[`APC_B_M1SRC_HI:`APC_B_M1SRC_LO];
      attenuation_level    <= eff_b[`APC_B_VOL_HI:`APC_B_VOL_LO];
      attenuation_db       <= {2'h0, eff_b[`APC_B_VOL_HI:`APC_B_VOL_LO]}
                              << 2;
      volume_source_select <= eff_b[`APC_B_VSRC_HI:`APC_B_VSRC_LO];
      analog_out_source_select <= eff_a[`APC_A_AOSRC_HI:`APC_A_AOSRC_LO];
      analog_out_powerdown <= eff_a[`APC_A_ANALOG_OUT_POWERDOWN];
      output_source_select <= eff_a[`APC_A_OSRC_HI:`APC_A_OSRC_LO];
      speaker_aux_control  <= eff_a[`APC_A_SPK_HI:`APC_A_SPK_LO];
      volume_powerdown     <= eff_a[`APC_A_VOL_PD];
      aux_in_powerdown     <= eff_a[`APC_A_AUX_PD];
      analog_in_powerdown  <= eff_a[`APC_A_AIN_PD];
      input_source_select  <= eff_a[`APC_A_INSRC];
      aux_in_gain          <= eff_a[`APC_A_AUXG_HI:`APC_A_AUXG_LO];
      analog_in_gain       <= eff_a[`APC_A_AING_HI:`APC_A_AING_LO];
    end
  end
endmodule
`default_nettype wire

// File: pkg/apc_regs.vh
// apc_regs.vh: constants for the audio path configuration register bank
// assumes plain verilog-2005 consumers that include it by bare name
`ifndef APC_REGS_VH
`define APC_REGS_VH

// serial frame layout: 8-bit opcode then 16 data bits
`define APC_OPC_W        8
`define APC_DATA_W       16
`define APC_FRAME_W      24
`define APC_CNT_W        5
`define APC_CNT_ZERO     5'h00
`define APC_CNT_ONE      5'h01
// opcode patterns with bit 5 masked (don't care)
`define APC_OPC_MASK     8'hdf
`define APC_OPC_LOAD_A   8'h42
`define APC_OPC_LOAD_B   8'h44
// reset values of holding and active registers (all stages powered down)
`define APC_RST_A        16'h2421
`define APC_RST_B        16'hffff
// config b fields
`define APC_B_AGC_PD     0
`define APC_B_LPF_PD     1
`define APC_B_RATE_HI    3
`define APC_B_RATE_LO    2
`define APC_B_FILT_SRC   4
`define APC_B_MIX2_HI    6
`define APC_B_MIX2_LO    5
`define APC_B_MIX1_HI    8
`define APC_B_MIX1_LO    7
`define APC_B_M1SRC_HI   10
`define APC_B_M1SRC_LO   9
`define APC_B_VOL_HI     13
`define APC_B_VOL_LO     11
`define APC_B_VSRC_HI    15
`define APC_B_VSRC_LO    14
// config a fields
`define APC_A_VOL_PD     0
`define APC_A_SPK_HI     2
`define APC_A_SPK_LO     1
`define APC_A_OSRC_HI    4
`define APC_A_OSRC_LO    3
`define APC_A_ANALOG_OUT_POWERDOWN       5
`define APC_A_AOSRC_HI   8
`define APC_A_AOSRC_LO   6
`define APC_A_INSRC      9
`define APC_A_AUX_PD     10
`define APC_A_AUXG_HI    12
`define APC_A_AUXG_LO    11
`define APC_A_AIN_PD     13
`define APC_A_AING_HI    15
`define APC_A_AING_LO    14
// mixer mode code that powers a summing amp down
`define APC_MIX_OFF      2'h3
// attenuation step in db per volume code
`define APC_ATT_STEP_DB  5'h04

`endif

// File: logic/apc_sync.v
// apc_sync.v: three-stage input synchroniser with agreement filter
// assumes the input is asynchronous to clk; output changes once
// stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module apc_sync #(
  parameter RST_VAL = 1'b0
)(
  input  wire clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // first stage feeds only the second, keeps metastability contained
  always @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      dout   <= RST_VAL;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end
endmodule
`default_nettype wire

// File: logic/apc_serial_rx.v
// apc_serial_rx.v: spi mode 0 shifter for opcode plus 16 data bits
// assumes synchronised sclk, mosi and select levels on clk domain
`timescale 1ns/1ns
`include "apc_regs.vh"
`default_nettype none
module apc_serial_rx (
  input  wire                     clk,
  input  wire                     rst,
  input  wire                     ss_n,
  input  wire                     sclk,
  input  wire                     mosi,
  output reg  [`APC_FRAME_W-1:0]  frame,
  output reg  [`APC_CNT_W-1:0]    bit_cnt,
  output reg                      ss_rise
);
  reg sclk_d_reg;
  reg ss_d_reg;

  // sample mosi on sclk rise while selected; count saturates
  always @(posedge clk)
  begin
    if (rst)
    begin
      sclk_d_reg <= 1'b0;
      ss_d_reg   <= 1'b1;
      frame      <= {`APC_FRAME_W{1'b0}};
      bit_cnt    <= `APC_CNT_ZERO;
      ss_rise    <= 1'b0;
    end
    else
    begin
      sclk_d_reg <= sclk;
      ss_d_reg   <= ss_n;
      ss_rise    <= ss_n & ~ss_d_reg;
      // count clears one cycle after the select rise, so the frame
      // length still stands while the commit decode looks at it
      if (ss_n & ss_d_reg)
        bit_cnt <= `APC_CNT_ZERO;
      else if (sclk & ~sclk_d_reg)
      begin
        frame <= {frame[`APC_FRAME_W-2:0], mosi};
        if (bit_cnt != 5'h1f)
          bit_cnt <= bit_cnt + `APC_CNT_ONE;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/apc_host_model.sv
// apc_host_model.sv: host side of the serial port, mode 0, msb first
// assumes clk is the bench clock; sclk stands low between frames
`timescale 1ns/1ns
`default_nettype none
module apc_host_model (
  input  wire logic clk,
  output logic      ss_n,
  output logic      sclk,
  output logic      mosi
);
  // idle pins from time zero
  initial
  begin
    ss_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // wait n edges, then step off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // opcode then data bits
  // short frames are only sent to provoke a refusal
  task automatic send_frame(input logic [7:0] op, input logic [15:0] d,
                            input int nbits);
    logic [23:0] f;
    f = {op, d};
    ss_n = 1'b0;
    for (int i = 23; i > 23 - nbits; i--)
    begin
      mosi = f[i];
      hold(4);
      sclk = 1'b1;
      hold(4);
      sclk = 1'b0;
    end
    hold(4);
    ss_n = 1'b1;
    mosi = ~mosi;  // released line must not keep its last bit
    hold(9);
  endtask
endmodule
`default_nettype wire

// File: verification/apc_config_regs_properties.sv
// apc_config_regs_properties.sv: port checks for the config bank
// assumes a bind onto apc_config_regs, single clk domain
`timescale 1ns/1ns
`default_nettype none
module apc_config_regs_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ss_n,
  input wire logic        master_power_bit,
  input wire logic [15:0] audio_path_config_a_reg,
  input wire logic [15:0] audio_path_config_b_reg,
  input wire logic        agc_amp_powerdown,
  input wire logic [1:0]  rate_filter_select,
  input wire logic [2:0]  attenuation_level,
  input wire logic [4:0]  attenuation_db,
  input wire logic [1:0]  second_mixer_mode,
  input wire logic        second_mixer_powerdown,
  input wire logic [1:0]  volume_source_select,
  input wire logic        analog_out_powerdown,
  input wire logic [2:0]  analog_out_source_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // power held off long enough to pass the synchroniser
  sequence s_power_off;
    !master_power_bit [*8];
  endsequence
  // any commit of the active registers
  sequence s_commit;
    $changed(audio_path_config_a_reg) || $changed(audio_path_config_b_reg);
  endsequence
  a_reset_values: assert property ($fell(rst) |->
    audio_path_config_a_reg == 16'h2421 &&
    audio_path_config_b_reg == 16'hffff && agc_amp_powerdown)
    else $error("reset values wrong");
  a_commit_after_select: assert property (s_commit |->
    $past(ss_n) && $past(ss_n, 4)) else $error("commit while selected");
  a_agc_field_src: assert property (!agc_amp_powerdown |->
    !$past(audio_path_config_b_reg[0])) else $error("agc field wrong");
  a_rate_field_src: assert property (rate_filter_select != 2'h3 |->
    rate_filter_select == $past(audio_path_config_b_reg[3:2]))
    else $error("rate field wrong");
  a_atten_db_scale: assert property (
    attenuation_db == {attenuation_level, 2'b00})
    else $error("attenuation scale wrong");
  a_mixer2_off: assert property (
    second_mixer_powerdown == (second_mixer_mode == 2'h3))
    else $error("second mixer powerdown wrong");
  a_vol_src_field: assert property (volume_source_select != 2'h3 |->
    volume_source_select == $past(audio_path_config_b_reg[15:14]))
    else $error("volume source wrong");
  a_out_src_field: assert property (!analog_out_powerdown |->
    analog_out_source_select == $past(audio_path_config_a_reg[8:6]))
    else $error("analog out source wrong");
  a_power_off_hold: assert property (s_power_off |->
    agc_amp_powerdown && rate_filter_select == 2'h3 &&
    volume_source_select == 2'h3) else $error("fields live while off");
endmodule
bind apc_config_regs apc_config_regs_properties u_apc_config_regs_properties (
  .clk(clk), .rst(rst), .ss_n(ss_n), .master_power_bit(master_power_bit),
  .audio_path_config_a_reg(audio_path_config_a_reg),
  .audio_path_config_b_reg(audio_path_config_b_reg),
  .agc_amp_powerdown(agc_amp_powerdown),
  .rate_filter_select(rate_filter_select),
  .attenuation_level(attenuation_level), .attenuation_db(attenuation_db),
  .second_mixer_mode(second_mixer_mode),
  .second_mixer_powerdown(second_mixer_powerdown),
  .volume_source_select(volume_source_select),
  .analog_out_powerdown(analog_out_powerdown),
  .analog_out_source_select(analog_out_source_select));
`default_nettype wire

// File: verification/tb_apc_config_regs.sv
// tb_apc_config_regs.sv: self-checking bench for the config bank
// assumes the host model drives the serial pins; pu is driven here
`timescale 1ns/1ns
`default_nettype none
module tb_apc_config_regs;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pu = 1'b0;
  logic [2:0]  k;
  wire         ss_n, sclk, mosi;
  wire  [15:0] a_reg, b_reg;
  wire  [38:0] flds;
  int          num_errors = 0;
  int          tests_run = 0;
  apc_host_model u_apc_host_model (.clk(clk), .ss_n(ss_n), .sclk(sclk),
    .mosi(mosi));
  apc_config_regs u_apc_config_regs (.clk(clk), .rst(rst), .ss_n(ss_n),
    .sclk(sclk), .mosi(mosi), .master_power_bit(pu),
    .audio_path_config_a_reg(a_reg), .audio_path_config_b_reg(b_reg),
    .agc_amp_powerdown(flds[38]), .lowpass_powerdown(flds[37]),
    .rate_filter_select(flds[36:35]), .filter_source_select(flds[34]),
    .second_mixer_mode(flds[33:32]), .first_mixer_mode(flds[31:30]),
    .first_mixer_source_select(flds[29:28]),
    .attenuation_level(flds[27:25]), .attenuation_db(flds[24:20]),
    .volume_source_select(flds[19:18]),
    .analog_out_source_select(flds[17:15]),
    .analog_out_powerdown(flds[14]), .output_source_select(flds[13:12]),
    .speaker_aux_control(flds[11:10]), .volume_powerdown(flds[9]),
    .input_source_select(flds[8]), .aux_in_powerdown(flds[7]),
    .aux_in_gain(flds[6:5]), .analog_in_powerdown(flds[4]),
    .analog_in_gain(flds[3:2]), .second_mixer_powerdown(flds[1]),
    .first_mixer_powerdown(flds[0]));
  // 125 MHz clock
  always #4 clk = ~clk;
  // rest of the decode; off shows reset
  function automatic logic [38:0] fields_of(input logic [15:0] a,
    input logic [15:0] b, input logic on);
    if (!on)
    begin
      a = 16'h2421;
      b = 16'hffff;
    end
    return {b[0], b[1], b[3:2], b[4], b[6:5], b[8:7], b[10:9], b[13:11],
      b[13:11], 2'b00, b[15:14], a[8:6], a[5], a[4:3], a[2:1], a[0],
      a[9], a[10], a[12:11], a[13], a[15:14], &b[6:5], &b[8:7]};
  endfunction
  task automatic fail(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp_reg(input logic [15:0] act, input logic [15:0] exp);
    tests_run++;
    if (act !== exp) fail($sformatf("reg %h, want %h", act, exp));
  endtask
  task automatic cmp_fields(input logic [38:0] exp);
    tests_run++;
    if (flds !== exp) fail($sformatf("fields %h, want %h", flds, exp));
  endtask
  task automatic check_all(input logic [15:0] ea, input logic [15:0] eb);
    cmp_reg(a_reg, ea);
    cmp_reg(b_reg, eb);
    cmp_fields(fields_of(ea, eb, pu));
  endtask
  task automatic load(input logic [7:0] op, input logic [15:0] d);
    u_apc_host_model.send_frame(op, d, 24);
  endtask
  // power pin passes a synchroniser, so allow it time to settle
  task automatic power(input logic v);
    u_apc_host_model.hold(1);
    pu = v;
    u_apc_host_model.hold(8);
  endtask
  task automatic done(input string n);
    $display("test %s ended, %0d mismatches so far", n, num_errors);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge clk);
    fail("run did not finish");
    report_and_stop;
  end
  // main sequence
  initial
  begin
    u_apc_host_model.hold(10);
    rst = 1'b0;
    u_apc_host_model.hold(4);
    check_all(16'h2421, 16'hffff);
    done("reset");
    load(8'h42, 16'h440b);
    check_all(16'h2421, 16'hffff);
    load(8'h44, 16'h01e3);
    check_all(16'h440b, 16'h01e3);
    power(1'b1);
    check_all(16'h440b, 16'h01e3);
    done("load while off");
    load(8'h62, 16'h2421);
    check_all(16'h440b, 16'h01e3);
    load(8'h64, 16'h0148);
    check_all(16'h2421, 16'h0148);
    u_apc_host_model.send_frame(8'h44, 16'h0000, 23);
    load(8'h60, 16'h0000);
    check_all(16'h2421, 16'h0148);
    done("x bit and refusals");
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      load(8'h42, {k[1:0], k[0], k[1:0], k[1], k[0], k, k[0], k[1:0],
        k[1:0], k[1]});
      load(8'h44, {k[1:0], k, k[1:0], k[1:0], k[1:0], k[0], k[1:0],
        k[1], k[0]});
      check_all({k[1:0], k[0], k[1:0], k[1], k[0], k, k[0], k[1:0],
        k[1:0], k[1]}, {k[1:0], k, k[1:0], k[1:0], k[1:0], k[0],
        k[1:0], k[1], k[0]});
    end
    done("field codes");
    power(1'b0);
    check_all(16'hffff, 16'hffff);
    done("power off");
    report_and_stop;
  end
endmodule
`default_nettype wire
